// file: design/vic_ctrl.sv
// Vectored interrupt control: request flags, enables, priority, vector table and APB slave.
//
// Functional notes
// - Nine sources feed the controller; nesting follows the software-marked vector, not priority.
// - Simultaneous requests: vector 1 wins, vector 6 loses.
// - Dual-edge pin requests on both edges; shares vector 1 with basic timer.
// - Basic interval timer tick raises its own internal request.
// - Edge-selectable pins A and B use vectors 2 and 3, edge chosen by software.
// - Serial transfer completion raises vector 4.
// - Timer count equal to modulo raises vector 5.
// - Pulse generator match raises vector 6.
// - Key and clock timer sources only set testable flags, never vector.
// - Key flag set by key pin rising or any key return falling.
// - Clock timer signal raises the clock timer flag.
// - Vectored request taken only with source enable and master enable.
// - Software writes each vector start address.
// - Software picks the vector that may nest over others.
// - Every request flag is readable by software.
// - Only enabled sources release standby.
// - All flags and control fields sit in the register map.
// - Flag set on request, cleared when the CPU accepts the interrupt.
// - Set vectored flag with its enable drives the vector line and wake; enabled key and clock timer flags drive wake only.
// - Software set of a flag vectors just like hardware.
// - Reset clears all request and enable flags.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps

module vic_ctrl
	import vic_pkg::*;
(
	// Clock and reset.
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave.
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Internal event pulses.
	input  wire logic                       basic_timer_irq,
	input  wire logic                       serial_done_irq,
	input  wire logic                       timer_match_irq,
	input  wire logic                       pulse_gen_match_irq,
	input  wire logic                       clock_timer_irq,
	// External pins.
	input  wire logic                       dual_edge_ext_irq,
	input  wire logic                       edge_select_ext_irq_a,
	input  wire logic                       edge_select_ext_irq_b,
	input  wire logic                       key_ext_irq,
	input  wire logic [NUM_KEY_RETURNS-1:0] key_return_inputs,
	// CPU core side.
	input  wire logic                       cpu_in_service,
	input  wire logic                       cpu_in_service_high,
	input  wire logic                       cpu_ack,
	input  wire logic [2:0]                 cpu_ack_num,
	output logic      [NUM_VECTORS:1]       vector_request_line,
	output vic_cpu_req_t                    cpu_req,
	output logic                            standby_release
);

	vic_state_t                    st_reg;
	vic_state_t                    st_next;
	logic [11:0]                   pin_level;
	vic_edge_sel_t [11:0]          edge_sel;
	logic [11:0]                   edge_pulse;
	logic [NUM_SOURCES-1:0]        hw_set;
	logic [NUM_VECTORS:1]          vrq;
	logic                          wr_access;
	logic                          rd_setup;
	logic                          addr_ok;
	logic [2:0]                    pick;

	// Ordered vector request lines from flags and enables.
	// The testable key and clock timer flags have no line, so they can never vector.
	function automatic logic [NUM_VECTORS:1] vic_vrq(input logic [NUM_SOURCES-1:0] req,
		input logic [NUM_SOURCES-1:0] en);
		logic [NUM_SOURCES-1:0] act;
		act = req & en;
		vic_vrq[1] = act[SRC_BASIC_TIMER] | act[SRC_DUAL_EDGE];
		vic_vrq[2] = act[SRC_EDGE_A];
		vic_vrq[3] = act[SRC_EDGE_B];
		vic_vrq[4] = act[SRC_SERIAL];
		vic_vrq[5] = act[SRC_TIMER];
		vic_vrq[6] = act[SRC_PULSE_GEN];
	endfunction : vic_vrq

	// Lowest numbered active line wins; zero means none.
	function automatic logic [2:0] vic_pick(input logic [NUM_VECTORS:1] lines);
		vic_pick = 3'h0;
		for (int v = NUM_VECTORS; v >= 1; v--) begin
			if (lines[v]) begin
				vic_pick = 3'(v);
			end
		end
	endfunction : vic_pick

	// Decodes whether an address is a mapped register.
	function automatic logic vic_mapped(input logic [7:0] a);
		vic_mapped = (a == OFS_CTRL) || (a == OFS_ENABLE) || (a == OFS_REQUEST)
			|| (a == OFS_REQ_SET) || (a == OFS_STATUS)
			|| ((a >= OFS_VECTOR1) && (a < 8'(OFS_VECTOR1 + NUM_VECTORS * OFS_VEC_STEP))
				&& (a[1:0] == 2'h0));
	endfunction : vic_mapped

	// Pin bank: dual edge, pins A and B, key pin, then eight key returns.
	// Key returns idle high and only their falling edge counts, so a cleared
	// previous level cannot raise a false key request after reset.
	always_comb begin
		pin_level = {key_return_inputs, key_ext_irq, edge_select_ext_irq_b,
			edge_select_ext_irq_a, dual_edge_ext_irq};
		edge_sel[0] = '{rise: 1'b1, fall: 1'b1};
		edge_sel[1] = '{rise: ~st_reg.edge_a_fall, fall: st_reg.edge_a_fall};
		edge_sel[2] = '{rise: ~st_reg.edge_b_fall, fall: st_reg.edge_b_fall};
		edge_sel[3] = '{rise: 1'b1, fall: 1'b0};
		for (int k = 4; k < 12; k++) begin
			edge_sel[k] = '{rise: 1'b0, fall: 1'b1};
		end
	end

	vic_edge #(
		.WIDTH      (12)
	) u_edge (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_level  (pin_level),
		.edge_sel   (edge_sel),
		.edge_pulse (edge_pulse)
	);

	// Hardware set terms of the nine request flags.
	always_comb begin
		hw_set                  = '0;
		hw_set[SRC_BASIC_TIMER] = basic_timer_irq;
		hw_set[SRC_DUAL_EDGE]   = edge_pulse[0];
		hw_set[SRC_EDGE_A]      = edge_pulse[1];
		hw_set[SRC_EDGE_B]      = edge_pulse[2];
		hw_set[SRC_SERIAL]      = serial_done_irq;
		hw_set[SRC_TIMER]       = timer_match_irq;
		hw_set[SRC_PULSE_GEN]   = pulse_gen_match_irq;
		hw_set[SRC_KEY]         = edge_pulse[3] | (|edge_pulse[11:4]);
		hw_set[SRC_CLOCK_TIMER] = clock_timer_irq;
	end

	// Bus strobes; zero wait states, so the access phase always completes.
	// Refused offsets answer with an error in the access phase and change nothing.
	// Read data comes from a register, so prdata has no path from the flags.
	assign wr_access = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable & ~pwrite;
	assign addr_ok   = vic_mapped(paddr);
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~addr_ok;

	// Request lines and winner from the current flags.
	assign vrq  = vic_vrq(st_reg.request, st_reg.enable);
	assign pick = vic_pick(vrq);

	// Next state: bus writes, flag set and clear, read data and CPU request.
	always_comb begin
		logic [NUM_SOURCES-1:0] clr;
		logic [NUM_SOURCES-1:0] sw_set;
		logic [7:0]             vofs;
		logic                   high;
		clr     = '0;
		sw_set  = '0;
		vofs    = 8'(paddr - OFS_VECTOR1);
		high    = 1'b0;
		st_next = st_reg;

		// Register writes take effect on the access edge only.
		if (wr_access && addr_ok) begin
			case (paddr)
				OFS_CTRL: begin
					st_next.mie         = pwdata[CTRL_MIE_BIT];
					st_next.nest_sel    = pwdata[CTRL_NEST_LSB +: 3];
					st_next.edge_a_fall = pwdata[CTRL_EDGE_A_BIT];
					st_next.edge_b_fall = pwdata[CTRL_EDGE_B_BIT];
				end
				OFS_ENABLE: begin
					st_next.enable = pwdata[NUM_SOURCES-1:0];
				end
				OFS_REQUEST: begin
					clr = pwdata[NUM_SOURCES-1:0];
				end
				OFS_REQ_SET: begin
					sw_set = pwdata[NUM_SOURCES-1:0];
				end
				// Status is read only; a write to it is accepted and dropped.
				OFS_STATUS: begin
				end
				default: begin
					st_next.vec_addr[vofs[4:2]] = pwdata[VEC_ADDR_W-1:0];
				end
			endcase
		end

		// Acceptance by the CPU clears the flags behind that vector. The shared
		// vector clears the timer flag first; a pending pin edge then reasserts it.
		// Acknowledging a vector whose flags are already clear does nothing.
		if (cpu_ack) begin
			case (cpu_ack_num)
				3'h1: begin
					if (st_reg.request[SRC_BASIC_TIMER] && st_reg.enable[SRC_BASIC_TIMER]) begin
						clr[SRC_BASIC_TIMER] = 1'b1;
					end else begin
						clr[SRC_DUAL_EDGE] = 1'b1;
					end
				end
				3'h2: begin
					clr[SRC_EDGE_A] = 1'b1;
				end
				3'h3: begin
					clr[SRC_EDGE_B] = 1'b1;
				end
				3'h4: begin
					clr[SRC_SERIAL] = 1'b1;
				end
				3'h5: begin
					clr[SRC_TIMER] = 1'b1;
				end
				3'h6: begin
					clr[SRC_PULSE_GEN] = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// A set in the clearing cycle wins, so no event is lost.
		st_next.request = (st_reg.request & ~clr) | hw_set | sw_set;

		// Read data is captured in the setup phase and presented in the access phase.
		if (rd_setup) begin
			st_next.prdata = 32'h0000_0000;
			case (paddr)
				OFS_CTRL: begin
					st_next.prdata[CTRL_MIE_BIT]      = st_reg.mie;
					st_next.prdata[CTRL_NEST_LSB +: 3] = st_reg.nest_sel;
					st_next.prdata[CTRL_EDGE_A_BIT]   = st_reg.edge_a_fall;
					st_next.prdata[CTRL_EDGE_B_BIT]   = st_reg.edge_b_fall;
				end
				OFS_ENABLE: begin
					st_next.prdata[NUM_SOURCES-1:0] = st_reg.enable;
				end
				OFS_REQUEST: begin
					st_next.prdata[NUM_SOURCES-1:0] = st_reg.request;
				end
				OFS_REQ_SET: begin
					st_next.prdata[NUM_SOURCES-1:0] = st_reg.request;
				end
				OFS_STATUS: begin
					st_next.prdata[STAT_VRQ_LSB +: NUM_VECTORS] = vrq;
					st_next.prdata[STAT_WAKE_BIT]              = st_reg.wake;
					st_next.prdata[STAT_NUM_LSB +: 3]          = pick;
				end
				default: begin
					if (addr_ok) begin
						st_next.prdata[VEC_ADDR_W-1:0] = st_reg.vec_addr[vofs[4:2]];
					end
				end
			endcase
		end

		// The request is registered, so it trails the flags by one cycle; the core must
		// acknowledge only while take is high, or it would clear a flag it never served.
		// Nesting: in a service, only the vector software marked may break in,
		// and only over a service that is not itself the marked one.
		high = (pick != 3'h0) && (pick == st_reg.nest_sel);
		st_next.cpu.take       = st_reg.mie && (pick != 3'h0)
			&& (!cpu_in_service || (high && !cpu_in_service_high));
		st_next.cpu.num        = pick;
		st_next.cpu.nest_high  = high;
		st_next.cpu.table_addr = (pick == 3'h0) ? 16'h0000
			: 16'(VEC_TABLE_BASE + VEC_TABLE_STEP * 16'(pick - 3'h1));
		st_next.cpu.start_addr = (pick == 3'h0) ? VEC_ADDR_RST
			: st_reg.vec_addr[pick - 3'h1];
		// Testable sources wake the core too when enabled; master enable plays no part.
		st_next.wake = |(st_reg.request & st_reg.enable);
	end

	// State register; everything starts cleared and disabled.
	// Every field gets a constant here, so the reset path needs no next-state logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.mie         <= 1'b0;
			st_reg.nest_sel    <= NEST_RST;
			st_reg.edge_a_fall <= 1'b0;
			st_reg.edge_b_fall <= 1'b0;
			st_reg.enable      <= FLAGS_RST;
			st_reg.request     <= FLAGS_RST;
			st_reg.vec_addr    <= {NUM_VECTORS{VEC_ADDR_RST}};
			st_reg.prdata      <= 32'h0000_0000;
			st_reg.cpu         <= '0;
			st_reg.wake        <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs; vector lines follow the flags directly for the core's sequencer.
	assign prdata              = st_reg.prdata;
	assign cpu_req             = st_reg.cpu;
	assign standby_release     = st_reg.wake;
	assign vector_request_line = vrq;

endmodule : vic_ctrl

// file: design/vic_edge.sv
// Edge detector bank that turns pin levels into one-cycle request pulses.
`timescale 1ns/100ps

module vic_edge
	import vic_pkg::*;
#(
	parameter int unsigned WIDTH = 12
) (
	// Clock and reset.
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Pin levels and edge choices.
	input  wire logic [WIDTH-1:0]      pin_level,
	input  wire vic_edge_sel_t [WIDTH-1:0] edge_sel,
	// Detected edges.
	output logic      [WIDTH-1:0]      edge_pulse
);

	logic [WIDTH-1:0] prev_reg;

	// Previous level; reset to low so a pin held high at reset reads as a rising edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= pin_level;
		end
	end

	// An edge counts only in the directions chosen for that input.
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			edge_pulse[i] = (edge_sel[i].rise & pin_level[i] & ~prev_reg[i])
				| (edge_sel[i].fall & ~pin_level[i] & prev_reg[i]);
		end
	end

endmodule : vic_edge

// file: design/vic_pkg.sv
// Package with register map, field layout and state types of the vectored interrupt control.
package vic_pkg;

	// Source numbering inside the request and enable words.
	localparam int unsigned SRC_BASIC_TIMER = 0;
	localparam int unsigned SRC_DUAL_EDGE   = 1;
	localparam int unsigned SRC_EDGE_A      = 2;
	localparam int unsigned SRC_EDGE_B      = 3;
	localparam int unsigned SRC_SERIAL      = 4;
	localparam int unsigned SRC_TIMER       = 5;
	localparam int unsigned SRC_PULSE_GEN   = 6;
	localparam int unsigned SRC_KEY         = 7;
	localparam int unsigned SRC_CLOCK_TIMER = 8;
	localparam int unsigned NUM_SOURCES     = 9;
	localparam int unsigned NUM_VECTORS     = 6;
	localparam int unsigned VEC_ADDR_W      = 14;
	localparam int unsigned NUM_KEY_RETURNS = 8;

	// Register byte offsets on the APB.
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_ENABLE   = 8'h04;
	localparam logic [7:0] OFS_REQUEST  = 8'h08;
	localparam logic [7:0] OFS_REQ_SET  = 8'h0c;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_VECTOR1  = 8'h20;
	localparam logic [7:0] OFS_VEC_STEP = 8'h04;

	// Control register field positions.
	localparam int unsigned CTRL_MIE_BIT    = 0;
	localparam int unsigned CTRL_NEST_LSB   = 4;
	localparam int unsigned CTRL_EDGE_A_BIT = 8;
	localparam int unsigned CTRL_EDGE_B_BIT = 9;

	// Status register field positions.
	localparam int unsigned STAT_VRQ_LSB  = 0;
	localparam int unsigned STAT_WAKE_BIT = 8;
	localparam int unsigned STAT_NUM_LSB  = 12;

	// Values after reset.
	localparam logic [VEC_ADDR_W-1:0]  VEC_ADDR_RST = 14'h0000;
	localparam logic [NUM_SOURCES-1:0] FLAGS_RST    = 9'h000;
	localparam logic [2:0]             NEST_RST     = 3'h0;

	// Vector table start addresses, index 0 is vector 1.
	localparam logic [15:0] VEC_TABLE_BASE = 16'h0002;
	localparam logic [15:0] VEC_TABLE_STEP = 16'h0002;

	// Edge detector settings per input.
	typedef struct packed {
		logic rise;
		logic fall;
	} vic_edge_sel_t;

	// Request offered to the CPU core.
	typedef struct packed {
		logic                  take;
		logic [2:0]            num;
		logic [15:0]           table_addr;
		logic [VEC_ADDR_W-1:0] start_addr;
		logic                  nest_high;
	} vic_cpu_req_t;

	// Whole state of the controller.
	typedef struct packed {
		logic                                   mie;
		logic [2:0]                             nest_sel;
		logic                                   edge_a_fall;
		logic                                   edge_b_fall;
		logic [NUM_SOURCES-1:0]                 enable;
		logic [NUM_SOURCES-1:0]                 request;
		logic [NUM_VECTORS-1:0][VEC_ADDR_W-1:0] vec_addr;
		logic [31:0]                            prdata;
		vic_cpu_req_t                           cpu;
		logic                                   wake;
	} vic_state_t;

endpackage : vic_pkg

// file: verif/vic_cpu_model.sv
// CPU core model that accepts vectored requests and logs each start address.
`timescale 1ns/100ps

module vic_cpu_model
	import vic_pkg::*;
(
	// Clock and reset.
	input  wire logic	pclk,
	input  wire logic	presetn,
	// Test controls.
	input  wire logic	auto_ack,
	input  wire logic	svc,
	input  wire logic	svc_high,
	// Controller side.
	input  wire vic_cpu_req_t	cpu_req,
	output logic	cpu_in_service,
	output logic	cpu_in_service_high,
	output logic	cpu_ack,
	output logic [2:0]	cpu_ack_num
);
	int unsigned	gap;
	logic [VEC_ADDR_W-1:0]	log_q[$];

	// Acks only while the request is up, then backs off until the flag clear has reached take.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cpu_in_service, cpu_in_service_high, cpu_ack, cpu_ack_num} <= '0;
			gap <= 0;
		end else begin
			cpu_in_service <= svc;
			cpu_in_service_high <= svc_high;
			cpu_ack <= 1'b0;
			if (gap != 0) begin
				gap <= gap - 1;
			end else if (auto_ack && cpu_req.take) begin
				cpu_ack <= 1'b1;
				cpu_ack_num <= cpu_req.num;
				log_q.push_back(cpu_req.start_addr);
				gap <= 3;
			end
		end
	end
endmodule : vic_cpu_model

// file: verif/vic_ctrl_props.sv
// Port-level assertions for the vectored interrupt control.
`timescale 1ns/100ps

module vic_ctrl_props
	import vic_pkg::*;
(
	// Clock and reset.
	input wire logic	pclk,
	input wire logic	presetn,
	// APB slave.
	input wire logic	psel,
	input wire logic	penable,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// CPU core side.
	input wire logic	cpu_in_service,
	input wire logic	cpu_in_service_high,
	input wire logic [NUM_VECTORS:1]	vector_request_line,
	input wire vic_cpu_req_t	cpu_req,
	input wire logic	standby_release
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Bus answers: zero wait, and only unmapped offsets are refused.
	a_pready_high: assert property (pready) else $error("pready low");
	a_slverr_unmapped: assert property (psel && penable |-> pslverr == !(paddr inside
		{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34}))
		else $error("pslverr wrong in access");
	a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
		else $error("pslverr outside access");
	a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved without setup");
	// The granted vector was pending and no higher one was.
	a_take_winner: assert property (cpu_req.take |-> ({$past(vector_request_line), 1'b0}
		& ((8'h2 << cpu_req.num) - 8'h1)) == (8'h1 << cpu_req.num))
		else $error("take not on highest pending vector");
	a_table_addr: assert property (cpu_req.take |->
		cpu_req.table_addr == {12'h000, cpu_req.num, 1'b0}) else $error("table address wrong");
	a_standby_wake: assert property (|vector_request_line |=> standby_release)
		else $error("no standby release");
	a_nest_block: assert property (cpu_in_service && cpu_in_service_high |=>
		!cpu_req.take) else $error("nested over marked service");

	// Main scenarios.
	c_vector_one: cover property (cpu_req.take && cpu_req.num == 3'd1);
	c_nested: cover property (cpu_req.take && cpu_in_service);
	c_refused: cover property (psel && penable && pslverr);
endmodule : vic_ctrl_props

bind vic_ctrl vic_ctrl_props i_vic_ctrl_props (.pclk, .presetn, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .cpu_in_service, .cpu_in_service_high, .vector_request_line,
	.cpu_req, .standby_release);

// file: verif/vic_ctrl_tb.sv
// Self-checking testbench of the vectored interrupt control with a CPU core model.
`timescale 1ns/100ps

module vic_ctrl_tb
	import vic_pkg::*;
;
	// Bus, source and core model signals; ev holds the nine sources in flag order.
	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr, sr;
	logic [7:0]	paddr, key_return_inputs;
	logic [31:0]	pwdata, prdata, rd;
	logic [8:0]	ev;
	logic	auto_ack, svc, svc_high, cpu_in_service, cpu_in_service_high;
	logic	cpu_ack, standby_release;
	logic [2:0]	cpu_ack_num;
	logic [NUM_VECTORS:1]	vector_request_line;
	vic_cpu_req_t	cpu_req;
	int	mismatches, tests_run;

	// Free running clock.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	vic_ctrl i_vic_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .basic_timer_irq(ev[0]), .dual_edge_ext_irq(ev[1]),
		.edge_select_ext_irq_a(ev[2]), .edge_select_ext_irq_b(ev[3]),
		.serial_done_irq(ev[4]), .timer_match_irq(ev[5]), .pulse_gen_match_irq(ev[6]),
		.key_ext_irq(ev[7]), .clock_timer_irq(ev[8]), .key_return_inputs, .cpu_in_service,
		.cpu_in_service_high, .cpu_ack, .cpu_ack_num, .vector_request_line, .cpu_req,
		.standby_release);
	vic_cpu_model i_vic_cpu_model (.pclk, .presetn, .auto_ack, .svc, .svc_high, .cpu_req,
		.cpu_in_service, .cpu_in_service_high, .cpu_ack, .cpu_ack_num);

	// One transfer; it ends a cycle after release so no signal is assigned twice at once.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		sr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rchk

	// Reads the request flags, then clears them all for the next case.
	task automatic fl(input logic [31:0] e);
		rchk("flags", OFS_REQUEST, e);
		apb(1'b1, OFS_REQUEST, 32'h1ff);
	endtask : fl

	// Sources are held for three cycles so edges and pulses are always seen.
	task automatic drive(input int b, input logic v);
		ev[b] <= v;
		repeat (3) @(posedge pclk);
	endtask : drive

	task automatic results;
		$display("Checks run %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ev, svc, svc_high} = '0;
		key_return_inputs = 8'hff;
		auto_ack = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("enable", OFS_ENABLE, 32'h0);
		fl(32'h0);
		rchk("unmapped", 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, sr});
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, OFS_VECTOR1 + 8'(4 * i), 32'h100 + i);
			rchk("vector", OFS_VECTOR1 + 8'(4 * i), 32'h100 + i);
		end
		// Every source alone, pins on their default rising edge.
		for (int b = 0; b < 9; b++) begin
			drive(b, 1'b1);
			drive(b, 1'b0);
			fl(32'h1 << b);
		end
		drive(1, 1'b1);
		fl(32'h2);
		drive(1, 1'b0);
		fl(32'h2);
		apb(1'b1, OFS_CTRL, 32'h300);
		for (int b = 2; b < 4; b++) begin
			drive(b, 1'b1);
			fl(32'h0);
			drive(b, 1'b0);
			fl(32'h1 << b);
		end
		key_return_inputs <= 8'hf7;
		repeat (3) @(posedge pclk);
		fl(32'h80);
		key_return_inputs <= 8'hff;
		// Enable gating of vector lines and wake-up.
		apb(1'b1, OFS_ENABLE, 32'h1ef);
		apb(1'b1, OFS_REQ_SET, 32'h190);
		rchk("status", OFS_STATUS, 32'h100);
		apb(1'b1, OFS_ENABLE, 32'h1ff);
		rchk("status", OFS_STATUS, 32'h4108);
		chk("standby", 32'h1, {31'h0, standby_release});
		apb(1'b1, OFS_ENABLE, 32'h0);
		rchk("status", OFS_STATUS, 32'h0);
		chk("standby", 32'h0, {31'h0, standby_release});
		fl(32'h190);
		// Fixed priority with vector 1 shared by two flags.
		apb(1'b1, OFS_ENABLE, 32'h1ff);
		apb(1'b1, OFS_REQ_SET, 32'h7f);
		apb(1'b1, OFS_CTRL, 32'h1);
		repeat (40) @(posedge pclk);
		for (int i = 0; i < 7; i++) begin
			chk("start", 32'h100 + (i > 0 ? i - 1 : 0), i_vic_cpu_model.log_q[i]);
		end
		fl(32'h0);
		// Nesting only for the marked vector, and not over itself.
		apb(1'b1, OFS_CTRL, 32'h31);
		svc <= 1'b1;
		apb(1'b1, OFS_REQ_SET, 32'h4);
		repeat (10) @(posedge pclk);
		fl(32'h4);
		apb(1'b1, OFS_REQ_SET, 32'h8);
		repeat (10) @(posedge pclk);
		chk("nest", 32'h102, i_vic_cpu_model.log_q[7]);
		svc_high <= 1'b1;
		apb(1'b1, OFS_REQ_SET, 32'h8);
		repeat (10) @(posedge pclk);
		chk("nest_high", 32'h1, {31'h0, cpu_req.nest_high});
		chk("take", 32'h0, {31'h0, cpu_req.take});
		fl(32'h8);
		chk("acks", 32'd8, 32'(i_vic_cpu_model.log_q.size()));
		results();
	end

	// Watchdog well beyond the few hundred cycles the sequence needs.
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		results();
	end
endmodule : vic_ctrl_tb
